//--- pkg/aqe_pkg.sv
// constants and types shared by both ends of the alert qualify block
package aqe_pkg;
    localparam int          NCH          = 4;
    localparam logic [7:0]  ADDR_UV_CNT  = 8'h48;
    localparam logic [7:0]  ADDR_ALERT_EN = 8'h49;
    localparam logic [7:0]  UV_CNT_RST   = 8'h00;
    localparam logic [23:0] EN_RST       = 24'h000000;
    localparam logic [23:0] EN_IMPL_MASK = 24'hFFFFFE;
    localparam int          OC_LSB       = 20;
    localparam int          UC_LSB       = 16;
    localparam int          OV_LSB       = 12;
    localparam int          UV_LSB       = 8;
    localparam int          OP_LSB       = 4;
    localparam int          ACC_FULL_BIT = 3;
    localparam int          TALLY_BIT    = 2;
    localparam int          CONV_BIT     = 1;
    localparam logic [4:0]  RUN_1        = 5'h01;
    localparam logic [4:0]  RUN_4        = 5'h04;
    localparam logic [4:0]  RUN_8        = 5'h08;
    localparam logic [4:0]  RUN_16       = 5'h10;
    typedef enum logic [1:0] {
        AQE_CMD_NONE,
        AQE_CMD_WRITE,
        AQE_CMD_READ,
        AQE_CMD_REFRESH
    } aqe_cmd_t;
endpackage

//--- pkg/aqe_if.sv
// register access link between host end and device end
`timescale 1ns/1ps
interface aqe_if;
    logic                 req;
    aqe_pkg::aqe_cmd_t    cmd;
    logic [7:0]           addr;
    logic [23:0]          wdata;
    logic                 ack;
    logic [23:0]          rdata;
    modport host (output req, cmd, addr, wdata, input ack, rdata);
    modport dev  (input req, cmd, addr, wdata, output ack, rdata);
endinterface

//--- core/aqe_device.sv
// device end: sample qualification, enable register, refresh, alert gating
`timescale 1ns/1ps
module aqe_device (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register link
    aqe_if.dev               bus,
    // condition inputs
    input  wire logic        sample_i,
    input  wire logic [3:0]  uv_viol_i,
    input  wire logic [3:0]  oc_i,
    input  wire logic [3:0]  uc_i,
    input  wire logic [3:0]  ov_i,
    input  wire logic [3:0]  op_i,
    input  wire logic        acc_full_i,
    input  wire logic        tally_full_i,
    input  wire logic        conv_done_i,
    // alert outputs
    output logic [23:0]      alert_vec_o,
    output logic             alert_o
);
    typedef struct packed {
        logic [7:0]      uv_cnt;
        logic [23:0]     en_shadow;
        logic [23:0]     en_active;
        logic [3:0][4:0] run;
        logic [3:0]      uv_qual;
        logic            ack;
        logic [23:0]     rdata;
        logic [23:0]     vec;
    } aqe_dev_state_t;

    aqe_dev_state_t s_q, s_d;

    function automatic logic [4:0] run_target(input logic [1:0] sel);
        unique case (sel)
            2'b00: run_target = aqe_pkg::RUN_1;
            2'b01: run_target = aqe_pkg::RUN_4;
            2'b10: run_target = aqe_pkg::RUN_8;
            2'b11: run_target = aqe_pkg::RUN_16;
        endcase
    endfunction

    always_comb begin
        logic [1:0]  sel;
        logic [23:0] raw;
        sel = 2'b00;
        raw = '0;
        s_d = s_q;
        s_d.ack = 1'b0;
        if (bus.req) begin
            s_d.ack = 1'b1;
            unique case (bus.cmd)
                aqe_pkg::AQE_CMD_WRITE: begin
                    if (bus.addr == aqe_pkg::ADDR_UV_CNT)
                        s_d.uv_cnt = bus.wdata[7:0];
                    else if (bus.addr == aqe_pkg::ADDR_ALERT_EN)
                        s_d.en_shadow = bus.wdata & aqe_pkg::EN_IMPL_MASK;
                end
                aqe_pkg::AQE_CMD_READ: begin
                    if (bus.addr == aqe_pkg::ADDR_UV_CNT)
                        s_d.rdata = {16'h0000, s_q.uv_cnt};
                    else if (bus.addr == aqe_pkg::ADDR_ALERT_EN)
                        s_d.rdata = s_q.en_shadow;
                    else
                        s_d.rdata = 24'h000000;
                end
                aqe_pkg::AQE_CMD_REFRESH:
                    s_d.en_active = s_q.en_shadow;
                aqe_pkg::AQE_CMD_NONE:
                    s_d.ack = 1'b0;
            endcase
        end
        // channel 1 sits in the top field, channel 4 in the lowest
        for (int c = 0; c < aqe_pkg::NCH; c++) begin
            sel = s_q.uv_cnt[2*(3-c) +: 2];
            if (sample_i) begin
                if (!uv_viol_i[3-c]) begin
                    s_d.run[c] = 5'h00;
                    s_d.uv_qual[c] = 1'b0;
                end else begin
                    // saturate so a long violation keeps the alert up
                    if (s_q.run[c] < aqe_pkg::RUN_16)
                        s_d.run[c] = s_q.run[c] + 5'h01;
                    s_d.uv_qual[c] =
                        ((s_q.run[c] + 5'h01) >= run_target(sel));
                end
            end
        end
        // vector index 3 is channel 1 so fields line up with enable bits
        raw[aqe_pkg::OC_LSB +: 4] = oc_i;
        raw[aqe_pkg::UC_LSB +: 4] = uc_i;
        raw[aqe_pkg::OV_LSB +: 4] = ov_i;
        raw[aqe_pkg::UV_LSB +: 4] = {s_q.uv_qual[0], s_q.uv_qual[1],
                                     s_q.uv_qual[2], s_q.uv_qual[3]};
        raw[aqe_pkg::OP_LSB +: 4] = op_i;
        raw[aqe_pkg::ACC_FULL_BIT] = acc_full_i;
        raw[aqe_pkg::TALLY_BIT] = tally_full_i;
        raw[aqe_pkg::CONV_BIT] = conv_done_i;
        s_d.vec = raw & s_q.en_active;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q.uv_cnt    <= aqe_pkg::UV_CNT_RST;
            s_q.en_shadow <= aqe_pkg::EN_RST;
            s_q.en_active <= aqe_pkg::EN_RST;
            s_q.run       <= '0;
            s_q.uv_qual   <= '0;
            s_q.ack       <= 1'b0;
            s_q.rdata     <= 24'h000000;
            s_q.vec       <= 24'h000000;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.ack     = s_q.ack;
    assign bus.rdata   = s_q.rdata;
    assign alert_vec_o = s_q.vec;
    assign alert_o     = |s_q.vec;
endmodule // aqe_device

//--- core/aqe_host.sv
// host end: issues single register commands, safe-update sequencing
`timescale 1ns/1ps
module aqe_host (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register link
    aqe_if.host              bus,
    // user side
    input  wire logic        go_i,
    input  wire logic        safe_i,
    input  aqe_pkg::aqe_cmd_t cmd_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [23:0] wdata_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [23:0]      rdata_o
);
    typedef enum logic [2:0] {
        H_IDLE, H_OFF, H_OFF_REF, H_MAIN, H_WAIT
    } aqe_hst_t;
    typedef struct packed {
        aqe_hst_t          st;
        logic              safe;
        aqe_pkg::aqe_cmd_t cmd;
        logic [7:0]        addr;
        logic [23:0]       wdata;
        logic              done;
        logic [23:0]       rdata;
    } aqe_host_state_t;

    aqe_host_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            H_IDLE: if (go_i) begin
                s_d.cmd   = cmd_i;
                s_d.addr  = addr_i;
                s_d.wdata = wdata_i;
                s_d.safe  = safe_i;
                // disable alerts first when limits or counts change
                s_d.st = safe_i ? H_OFF : H_MAIN;
            end
            H_OFF: if (bus.ack) s_d.st = H_OFF_REF;
            H_OFF_REF: if (bus.ack) s_d.st = H_MAIN;
            H_MAIN: if (bus.ack) s_d.st = H_WAIT;
            H_WAIT: begin
                s_d.st = H_IDLE;
                s_d.done = 1'b1;
                s_d.rdata = bus.rdata;
            end
            // three state codes are unused; fall back to idle
            default: s_d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q.st    <= H_IDLE;
            s_q.safe  <= 1'b0;
            s_q.cmd   <= aqe_pkg::AQE_CMD_NONE;
            s_q.addr  <= 8'h00;
            s_q.wdata <= 24'h000000;
            s_q.done  <= 1'b0;
            s_q.rdata <= 24'h000000;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        bus.req   = 1'b0;
        bus.cmd   = aqe_pkg::AQE_CMD_NONE;
        bus.addr  = 8'h00;
        bus.wdata = 24'h000000;
        if (s_q.st == H_OFF) begin
            bus.req  = !bus.ack;
            bus.cmd  = aqe_pkg::AQE_CMD_WRITE;
            bus.addr = aqe_pkg::ADDR_ALERT_EN;
        end else if (s_q.st == H_OFF_REF) begin
            bus.req = !bus.ack;
            bus.cmd = aqe_pkg::AQE_CMD_REFRESH;
        end else if (s_q.st == H_MAIN) begin
            bus.req   = !bus.ack;
            bus.cmd   = s_q.cmd;
            bus.addr  = s_q.addr;
            bus.wdata = s_q.wdata;
        end
    end

    assign busy_o  = (s_q.st != H_IDLE);
    assign done_o  = s_q.done;
    assign rdata_o = s_q.rdata;
endmodule // aqe_host

//--- tb/aqe_checker_sva.sv
// link and alert-pin assertions for the joined host and device ends
`timescale 1ns/1ps
module aqe_checker (
    // clock and reset
    input wire logic         clk_i,
    input wire logic         rst_i,
    // register link
    input wire logic         req,
    input aqe_pkg::aqe_cmd_t cmd,
    input wire logic [7:0]   addr,
    input wire logic         ack,
    input wire logic [23:0]  rdata,
    // conditions and alerts
    input wire logic [3:0]   oc_i,
    input wire logic [3:0]   uc_i,
    input wire logic [3:0]   ov_i,
    input wire logic [3:0]   op_i,
    input wire logic         acc_full_i,
    input wire logic         tally_full_i,
    input wire logic         conv_done_i,
    input wire logic [23:0]  alert_vec_o,
    input wire logic         alert_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence taken_s;
        req && cmd != aqe_pkg::AQE_CMD_NONE;
    endsequence
    sequence answer_s;
        ack ##1 !ack;
    endsequence
    // only the enable register has the unimplemented low bit
    sequence rd_en_s;
        req && cmd == aqe_pkg::AQE_CMD_READ
            && addr == aqe_pkg::ADDR_ALERT_EN;
    endsequence
    // an alert bit may only stand on a condition seen one cycle before
    property gated_p(logic [3:0] v, logic [3:0] c);
        v != 4'h0 |-> (v & ~$past(c)) == 4'h0;
    endproperty
    link_answer_a: assert property (taken_s |=> answer_s)
        else $error("link request not answered in one cycle");
    read_bit0_a: assert property (rd_en_s |=> ack && !rdata[0])
        else $error("unimplemented enable bit read as one");
    pin_or_a: assert property (alert_o == |alert_vec_o)
        else $error("alert pin differs from alert vector");
    oc_gate_a: assert property (gated_p(alert_vec_o[23:20], oc_i))
        else $error("overcurrent alert without condition");
    uc_gate_a: assert property (gated_p(alert_vec_o[19:16], uc_i))
        else $error("undercurrent alert without condition");
    ov_gate_a: assert property (gated_p(alert_vec_o[15:12], ov_i))
        else $error("overvoltage alert without condition");
    op_gate_a: assert property (gated_p(alert_vec_o[7:4], op_i))
        else $error("overpower alert without condition");
    misc_gate_a: assert property (gated_p(alert_vec_o[3:0],
        {acc_full_i, tally_full_i, conv_done_i, 1'b0}))
        else $error("status alert without condition");
endmodule // aqe_checker

//--- tb/test_alert_qualify_enable.sv
// self-checking bench: host end and device end joined over the link
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end
module test_alert_qualify_enable;
    logic              clk_i = 0, rst_i = 1, go_i = 0, safe_i = 0;
    logic              sample_i = 0, acc_full_i = 0, tally_full_i = 0;
    logic              conv_done_i = 0, busy_o, done_o, alert_o;
    logic [3:0]        uv_viol_i = 0, oc_i = 0, uc_i = 0, ov_i = 0, op_i = 0;
    logic [7:0]        addr_i = 8'h00;
    logic [23:0]       wdata_i = 24'h000000, rdata_o, alert_vec_o, c;
    aqe_pkg::aqe_cmd_t cmd_i = aqe_pkg::AQE_CMD_NONE;
    int                miscompares = 0, n_compared = 0;
    // enable value, condition pattern, expected alert vector
    logic [71:0] rows [9] = '{
        72'hF00000_FFF0FF_F00000, 72'h0F0000_FFF0FF_0F0000,
        72'h00F000_FFF0FF_00F000, 72'h0000F0_FFF0FF_0000F0,
        72'h000008_FFF0FF_000008, 72'h000004_FFF0FF_000004,
        72'h000002_FFF0FF_000002, 72'h000001_FFF0FF_000000,
        72'hA5A5A5_5AF05B_00A000};
    aqe_if bus ();
    aqe_host u_aqe_host (.clk_i, .rst_i, .bus(bus.host), .go_i, .safe_i,
        .cmd_i, .addr_i, .wdata_i, .busy_o, .done_o, .rdata_o);
    aqe_device u_aqe_device (.clk_i, .rst_i, .bus(bus.dev), .sample_i,
        .uv_viol_i, .oc_i, .uc_i, .ov_i, .op_i, .acc_full_i, .tally_full_i,
        .conv_done_i, .alert_vec_o, .alert_o);
    aqe_checker u_aqe_checker (.clk_i, .rst_i, .req(bus.req), .cmd(bus.cmd),
        .addr(bus.addr),
        .ack(bus.ack), .rdata(bus.rdata), .oc_i, .uc_i, .ov_i, .op_i,
        .acc_full_i, .tally_full_i, .conv_done_i, .alert_vec_o, .alert_o);
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic final_report();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one user command; the host sequences the link and pulses done
    task automatic op(aqe_pkg::aqe_cmd_t k, logic [7:0] a, logic [23:0] d,
                      logic s = 1'b0);
        int i;
        @(negedge clk_i);
        cmd_i = k;
        addr_i = a;
        wdata_i = d;
        safe_i = s;
        go_i = 1'b1;
        @(negedge clk_i);
        go_i = 1'b0;
        `CHK("busy", 1'b1, busy_o)
        for (i = 0; i < 40 && done_o !== 1'b1; i++) @(negedge clk_i);
        if (i == 40) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic cond(logic [23:0] v);
        {oc_i, uc_i, ov_i, op_i, acc_full_i, tally_full_i, conv_done_i} =
            {v[23:12], v[7:1]};
    endtask
    task automatic en(logic [23:0] v);
        op(aqe_pkg::AQE_CMD_WRITE, aqe_pkg::ADDR_ALERT_EN, v);
        op(aqe_pkg::AQE_CMD_REFRESH, 8'h00, 24'h000000);
        repeat (2) @(negedge clk_i);
    endtask
    initial begin
        #200us;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        foreach (rows[r]) begin
            cond(rows[r][47:24]);
            en(rows[r][71:48]);
            c = rows[r][23:0];
            `CHK("oc", c[23:20], alert_vec_o[23:20])
            `CHK("uc", c[19:16], alert_vec_o[19:16])
            `CHK("ov", c[15:12], alert_vec_o[15:12])
            `CHK("uv", c[11:8], alert_vec_o[11:8])
            `CHK("op", c[7:4], alert_vec_o[7:4])
            `CHK("acc", c[3], alert_vec_o[3])
            `CHK("tally", c[2], alert_vec_o[2])
            `CHK("conv", c[1], alert_vec_o[1])
            `CHK("bit0", c[0], alert_vec_o[0])
            `CHK("pin", |c, alert_o)
        end
        $display("test gating done");
        cond(24'hFFF0FF);
        op(aqe_pkg::AQE_CMD_WRITE, aqe_pkg::ADDR_ALERT_EN, 24'hFFFFFF);
        repeat (2) @(negedge clk_i);
        `CHK("stale", 24'hA5A0A4, alert_vec_o)
        op(aqe_pkg::AQE_CMD_READ, aqe_pkg::ADDR_ALERT_EN, 24'h000000);
        `CHK("en_rd", 24'hFFFFFE, rdata_o)
        en(24'hFFFFFF);
        `CHK("fresh", 24'hFFF0FE, alert_vec_o)
        op(aqe_pkg::AQE_CMD_WRITE, 8'h50, 24'hFFFFFF);
        op(aqe_pkg::AQE_CMD_READ, 8'h50, 24'h000000);
        `CHK("unmapped", 24'h000000, rdata_o)
        $display("test refresh done");
        cond(24'h000000);
        op(aqe_pkg::AQE_CMD_WRITE, aqe_pkg::ADDR_UV_CNT, 24'h00001B, 1'b1);
        op(aqe_pkg::AQE_CMD_READ, aqe_pkg::ADDR_UV_CNT, 24'h000000);
        `CHK("uv_cnt", 24'h00001B, rdata_o)
        en(24'h000F00);
        uv_viol_i = 4'hF;
        // codes 00,01,10,11 on ch1..ch4 need 1,4,8,16 samples in a row
        for (int k = 1; k <= 17; k++) begin
            sample_i = 1'b1;
            if (k == 17) uv_viol_i = 4'h0;
            @(negedge clk_i);
            sample_i = 1'b0;
            repeat (2) @(negedge clk_i);
            c[11:8] = {k >= 1, k >= 4, k >= 8, k >= 16};
            if (k < 17)
                `CHK("uv_run", c[11:8], alert_vec_o[11:8])
            else
                `CHK("uv_clr", 4'h0, alert_vec_o[11:8])
        end
        $display("test undervoltage run done");
        cond(24'hFFF0FF);
        en(24'hFFFFFF);
        op(aqe_pkg::AQE_CMD_WRITE, aqe_pkg::ADDR_UV_CNT, 24'h0000E4, 1'b1);
        `CHK("safe", 24'h000000, alert_vec_o)
        en(24'hFFFFFF);
        @(negedge clk_i);
        rst_i = 1'b1;
        #1;
        `CHK("rst_vec", 24'h000000, alert_vec_o)
        @(negedge clk_i);
        rst_i = 1'b0;
        op(aqe_pkg::AQE_CMD_READ, aqe_pkg::ADDR_ALERT_EN, 24'h000000);
        `CHK("rst_en", aqe_pkg::EN_RST, rdata_o)
        op(aqe_pkg::AQE_CMD_READ, aqe_pkg::ADDR_UV_CNT, 24'h000000);
        `CHK("rst_cnt", 24'h000000, rdata_o)
        `CHK("rst_off", 24'h000000, alert_vec_o)
        $display("test reset done");
        final_report();
    end
endmodule // test_alert_qualify_enable
